// [verilog/ocsc_ctrl.sv]
// Cycle-by-cycle ON/OFF switch controller with current-limit state machine
`timescale 1ns/1ns
`default_nettype none
`include "ocsc_map.svh"
module ocsc_ctrl #(
  parameter int OSC_DIV = `OCSC_OSC_DIV,
  parameter int HIST = `OCSC_HIST_DEPTH,
  parameter int HI_THR = `OCSC_HIST_HI_THR,
  parameter int LO_THR = `OCSC_HIST_LO_THR,
  parameter int unsigned NOFB_CYC = 32'((`OCSC_NOFB_TIME_MS * `OCSC_NS_PER_MS)
    / (`OCSC_CLK_PERIOD_NS * OSC_DIV)),
  parameter int unsigned AR_FIRST_CYC = 32'((`OCSC_AR_FIRST_MS * `OCSC_NS_PER_MS)
    / (`OCSC_CLK_PERIOD_NS * OSC_DIV)),
  parameter int unsigned AR_OFF_CYC = 32'((`OCSC_AR_OFF_MS * `OCSC_NS_PER_MS)
    / (`OCSC_CLK_PERIOD_NS * OSC_DIV))
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Sense comparators
  input wire logic feedback_enable_line_sense_input,
  input wire logic ilim_reached,
  input wire logic max_duty_window,
  input wire logic line_sense_ok,
  input wire logic line_sense_fitted,
  // Drive and status
  output logic switch_gate_ff,
  output ocsc_pkg::ocsc_ilim_t ilim_level_ff,
  output logic cycle_start_ff,
  output logic switching_on_ff,
  output logic latched_off_ff
);
  import ocsc_pkg::*;

  localparam int PCW = $clog2(HIST + 1);
  localparam int OW = $clog2(OSC_DIV);

  logic [`OCSC_SYNC_W-1:0] raw;
  logic [`OCSC_SYNC_W-1:0] syn;
  logic en_s, ilim_s, mdw_s, line_s, uvp_s;
  logic mdw_d_ff;
  logic mdw_fall;
  logic [OW-1:0] osc_cnt_ff;
  logic [HIST-1:0] hist_ff;
  logic [PCW-1:0] hist_ones;
  ocsc_state_t state_ff;
  ocsc_ilim_t nxt_ilim;
  logic first_ar_ff;
  logic [`OCSC_CNT_W-1:0] nofb_cnt;
  logic [`OCSC_CNT_W-1:0] off_cnt;
  logic nofb_expired;
  logic off_done;
  logic allow_sw;
  logic [1:0] settle_ff;

  // Comparator outputs are asynchronous to the clock
  assign raw = {line_sense_fitted, line_sense_ok, max_duty_window, ilim_reached,
                feedback_enable_line_sense_input};
  ocsc_sync #(.W(`OCSC_SYNC_W)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(raw),
    .q(syn)
  );
  assign en_s = syn[`OCSC_BIT_EN];
  assign ilim_s = syn[`OCSC_BIT_ILIM];
  assign mdw_s = syn[`OCSC_BIT_MDW];
  assign line_s = syn[`OCSC_BIT_LINE];
  assign uvp_s = syn[`OCSC_BIT_UVP];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mdw_d_ff <= 1'b0;
    end else begin
      mdw_d_ff <= mdw_s;
    end
  end
  assign mdw_fall = mdw_d_ff && !mdw_s;

  // Free-running oscillator, one start pulse per cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_cnt_ff <= '0;
      cycle_start_ff <= 1'b0;
    end else if (osc_cnt_ff == OW'(OSC_DIV - 1)) begin
      osc_cnt_ff <= '0;
      cycle_start_ff <= 1'b1;
    end else begin
      osc_cnt_ff <= osc_cnt_ff + {{(OW-1){1'b0}}, 1'b1};
      cycle_start_ff <= 1'b0;
    end
  end

  // Feedback side holds enable high while output is low; we rely on that polarity
  assign allow_sw = (state_ff == OCSC_ST_RUN) && en_s;

  // Gate: sampled only at cycle start, then only the terminators act
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      switch_gate_ff <= 1'b0;
    end else if (cycle_start_ff) begin
      switch_gate_ff <= allow_sw;
    end else if (ilim_s || mdw_fall) begin
      switch_gate_ff <= 1'b0;
    end // Enable is not looked at here
  end

  // Enable sample history
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Full history matches the full limit held in reset
      hist_ff <= '1;
    end else if (cycle_start_ff) begin
      hist_ff <= {hist_ff[HIST-2:0], en_s};
    end
  end

  always_comb begin
    hist_ones = '0;
    for (int i = 0; i < HIST; i++) begin
      hist_ones = hist_ones + PCW'(hist_ff[i]);
    end
  end

  // Current-limit level moves one step at a time to avoid audible jumps
  always_comb begin
    nxt_ilim = ilim_level_ff;
    case (ilim_level_ff)
      OCSC_ILIM_FULL: begin
        if (hist_ones < PCW'(HI_THR)) begin
          nxt_ilim = OCSC_ILIM_MED;
        end
      end
      OCSC_ILIM_MED: begin
        if (hist_ones >= PCW'(HI_THR)) begin
          nxt_ilim = OCSC_ILIM_FULL;
        end else if (hist_ones < PCW'(LO_THR)) begin
          nxt_ilim = OCSC_ILIM_LOW;
        end
      end
      OCSC_ILIM_LOW: begin
        if (hist_ones >= PCW'(LO_THR)) begin
          nxt_ilim = OCSC_ILIM_MED;
        end
      end
      default: begin
        nxt_ilim = OCSC_ILIM_FULL;
      end
    endcase
  end

  // Level changes only between cycles, never under a conducting gate
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ilim_level_ff <= OCSC_ILIM_FULL;
    end else if (cycle_start_ff) begin
      ilim_level_ff <= nxt_ilim;
    end
  end

  // No-feedback timer in oscillator cycles
  ocsc_cnt #(.W(`OCSC_CNT_W)) u_nofb (
    .clk(clk),
    .rst_b(rst_b),
    .clr((state_ff != OCSC_ST_RUN) || (cycle_start_ff && !en_s)),
    .inc(cycle_start_ff),
    .cnt_ff(nofb_cnt)
  );
  assign nofb_expired = nofb_cnt >= NOFB_CYC;

  // Auto-restart off-time timer
  ocsc_cnt #(.W(`OCSC_CNT_W)) u_off (
    .clk(clk),
    .rst_b(rst_b),
    .clr(state_ff != OCSC_ST_AROFF),
    .inc(cycle_start_ff),
    .cnt_ff(off_cnt)
  );
  assign off_done = first_ar_ff ? (off_cnt >= AR_OFF_CYC) : (off_cnt >= AR_FIRST_CYC);

  // Synchronised pins show reset values for two edges; line state is not trusted before then
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_ff <= '0;
    end else begin
      settle_ff <= {settle_ff[0], 1'h1};
    end
  end

  // Supervisor
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= OCSC_ST_PWRUP;
    end else begin
      case (state_ff)
        OCSC_ST_PWRUP: begin
          if (settle_ff[1] && (!uvp_s || line_s)) begin
            state_ff <= OCSC_ST_RUN;
          end
        end
        OCSC_ST_RUN: begin
          if (nofb_expired) begin
            if (!uvp_s) begin
              state_ff <= OCSC_ST_AROFF;
            end else if (line_s) begin
              state_ff <= OCSC_ST_LATCH;
            end else begin
              state_ff <= OCSC_ST_PWRUP;
            end
          end
        end
        OCSC_ST_LATCH: begin
          if (!line_s) begin
            state_ff <= OCSC_ST_PWRUP;
          end
        end
        OCSC_ST_AROFF: begin
          if (off_done) begin
            state_ff <= OCSC_ST_RUN;
          end
        end
        default: begin
          state_ff <= OCSC_ST_PWRUP;
        end
      endcase
    end
  end

  // First auto-restart uses the short off-time only once after reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_ar_ff <= 1'b0;
    end else if ((state_ff == OCSC_ST_AROFF) && off_done) begin
      first_ar_ff <= 1'b1;
    end
  end

  // Status outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      switching_on_ff <= 1'b0;
      latched_off_ff <= 1'b0;
    end else begin
      switching_on_ff <= state_ff == OCSC_ST_RUN;
      latched_off_ff <= state_ff == OCSC_ST_LATCH;
    end
  end

  // Checks
  gate_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    cycle_start_ff && allow_sw |=> switch_gate_ff)
    else $error("gate not on at enabled cycle start");
  gate_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    !cycle_start_ff && (ilim_s || mdw_fall) |=> !switch_gate_ff)
    else $error("gate not off at limit");
  skip_cycle_a: assert property (@(posedge clk) disable iff (!rst_b)
    cycle_start_ff && !en_s |=> !switch_gate_ff)
    else $error("disabled cycle switched");
  hold_cycle_a: assert property (@(posedge clk) disable iff (!rst_b)
    switch_gate_ff && !cycle_start_ff && !ilim_s && !mdw_fall |=> switch_gate_ff)
    else $error("cycle cut short");
  run_only_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(switch_gate_ff) |-> $past(state_ff) == OCSC_ST_RUN)
    else $error("switched outside run");
  osc_period_a: assert property (@(posedge clk) disable iff (!rst_b)
    cycle_start_ff |=> !cycle_start_ff [*2])
    else $error("oscillator pulse spacing wrong");
  latch_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_ff == OCSC_ST_LATCH && line_s |=> state_ff == OCSC_ST_LATCH)
    else $error("latch left with line present");
  nofb_trip_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_ff == OCSC_ST_RUN && nofb_expired && uvp_s && line_s |=> state_ff == OCSC_ST_LATCH)
    else $error("fault not latched");
  nofb_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_ff == OCSC_ST_RUN && cycle_start_ff && !en_s |=> nofb_cnt == '0)
    else $error("no-feedback timer not cleared");
  pwrup_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_ff == OCSC_ST_PWRUP && uvp_s && !line_s |=> state_ff == OCSC_ST_PWRUP)
    else $error("start below line threshold");
  latch_cov: cover property (@(posedge clk) disable iff (!rst_b) state_ff == OCSC_ST_LATCH);
  aroff_cov: cover property (@(posedge clk) disable iff (!rst_b) state_ff == OCSC_ST_AROFF);
  low_ilim_cov: cover property (@(posedge clk) disable iff (!rst_b)
    ilim_level_ff == OCSC_ILIM_LOW);
  settle_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_ff == OCSC_ST_PWRUP && !settle_ff[1] |=> state_ff == OCSC_ST_PWRUP)
    else $error("left power-up before pins settled");
  med_ilim_cov: cover property (@(posedge clk) disable iff (!rst_b)
    ilim_level_ff == OCSC_ILIM_MED);
  brownout_cov: cover property (@(posedge clk) disable iff (!rst_b)
    state_ff == OCSC_ST_RUN ##1 state_ff == OCSC_ST_PWRUP);
endmodule
`default_nettype wire

// [verilog/ocsc_map.svh]
// Constants for the ON/OFF switch cycle controller
`ifndef OCSC_MAP_SVH
`define OCSC_MAP_SVH
`define OCSC_CLK_PERIOD_NS 64'd100
`define OCSC_NS_PER_MS 64'd1000000
`define OCSC_NOFB_TIME_MS 64'd30
`define OCSC_AR_FIRST_MS 64'd150
`define OCSC_AR_OFF_MS 64'd5000
`define OCSC_OSC_DIV 40
`define OCSC_HIST_DEPTH 8
`define OCSC_HIST_HI_THR 6
`define OCSC_HIST_LO_THR 2
`define OCSC_SYNC_W 5
`define OCSC_BIT_EN 0
`define OCSC_BIT_ILIM 1
`define OCSC_BIT_MDW 2
`define OCSC_BIT_LINE 3
`define OCSC_BIT_UVP 4
`define OCSC_CNT_W 32
`endif

// [verilog/ocsc_pkg.sv]
// Types for the ON/OFF switch cycle controller
package ocsc_pkg;
  typedef enum logic [1:0] {OCSC_ILIM_FULL, OCSC_ILIM_MED, OCSC_ILIM_LOW} ocsc_ilim_t;
  typedef enum logic [1:0] {OCSC_ST_PWRUP, OCSC_ST_RUN, OCSC_ST_LATCH, OCSC_ST_AROFF} ocsc_state_t;
endpackage

// [verilog/ocsc_sync.sv]
// Two-stage synchroniser for asynchronous comparator inputs
`timescale 1ns/1ns
`default_nettype none
module ocsc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_ff;
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_ff <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta_ff <= d[i];
          q[i] <= meta_ff;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [verilog/ocsc_cnt.sv]
// Saturating event counter with synchronous clear
`timescale 1ns/1ns
`default_nettype none
module ocsc_cnt #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic clr,
  input wire logic inc,
  // Count
  output logic [W-1:0] cnt_ff
);
  // Saturate so a long stall never wraps back to a short count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
    end else if (clr) begin
      cnt_ff <= '0;
    end else if (inc && (cnt_ff != {W{1'b1}})) begin
      cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// [tb/ocsc_fb_model.sv]
// Feedback loop and power stage model facing the switch controller
`timescale 1ns/1ns
`default_nettype none
module ocsc_fb_model #(
  parameter int OSC_DIV = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Controller side
  input wire logic switch_gate_ff,
  input wire logic cycle_start_ff,
  // Scenario control
  input wire logic [1:0] mode,
  input wire logic [7:0] ilim_dly,
  // Comparator outputs
  output logic feedback_enable_line_sense_input,
  output logic ilim_reached,
  output logic max_duty_window
);
  int vout;
  int on_cnt;
  int dw_cnt;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vout = 0;
      on_cnt = 0;
      dw_cnt = 0;
      feedback_enable_line_sense_input <= 1'h0;
      ilim_reached <= 1'h0;
      max_duty_window <= 1'h0;
    end else begin
      // Load bleeds the output every cycle; each pulse recharges it
      if (cycle_start_ff && vout > 0) vout = vout - 1;
      if (switch_gate_ff && on_cnt == 0) vout = vout + 3;
      on_cnt = switch_gate_ff ? on_cnt + 1 : 0;
      dw_cnt = cycle_start_ff ? 0 : dw_cnt + 1;
      ilim_reached <= #1 (on_cnt >= ilim_dly);
      max_duty_window <= #1 (dw_cnt < OSC_DIV / 2);
      // Mode 0 regulates, 1 is an open loop, 2 a clamped output
      feedback_enable_line_sense_input <= #1 (mode == 2'h0) ? (vout < 4) : (mode == 2'h1);
    end
  end
endmodule
`default_nettype wire

// [tb/ocsc_ctrl_tb.sv]
// Self-checking bench for the switch cycle controller
`timescale 1ns/1ns
`default_nettype none
module ocsc_ctrl_tb;
  import ocsc_pkg::*;
  // Short timer counts keep the run brief
  localparam int DIV = 16;
  localparam int NOFB = 20;
  localparam int ARF = 40;
  localparam int ARO = 60;
  logic clk, rst_b, ilim_reached, max_duty_window, line_sense_ok, line_sense_fitted;
  logic fb_en, gate, cs, sw_on, latched;
  ocsc_ilim_t lvl;
  logic [1:0] mode;
  logic [7:0] ilim_dly;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  ocsc_ctrl #(.OSC_DIV(DIV), .NOFB_CYC(NOFB), .AR_FIRST_CYC(ARF), .AR_OFF_CYC(ARO)) DUT (
    .clk(clk), .rst_b(rst_b), .feedback_enable_line_sense_input(fb_en),
    .ilim_reached(ilim_reached), .max_duty_window(max_duty_window),
    .line_sense_ok(line_sense_ok), .line_sense_fitted(line_sense_fitted),
    .switch_gate_ff(gate), .ilim_level_ff(lvl), .cycle_start_ff(cs),
    .switching_on_ff(sw_on), .latched_off_ff(latched));
  ocsc_fb_model #(.OSC_DIV(DIV)) fb (
    .clk(clk), .rst_b(rst_b), .switch_gate_ff(gate), .cycle_start_ff(cs),
    .mode(mode), .ilim_dly(ilim_dly), .feedback_enable_line_sense_input(fb_en),
    .ilim_reached(ilim_reached), .max_duty_window(max_duty_window));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // A hang counts as a mismatch and still reaches the report
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic do_reset(input logic fit, input logic ok, input int len);
    if (rst_b === 1'h1) @(posedge clk) #1;
    rst_b = 1'h0;
    line_sense_fitted = fit;
    line_sense_ok = ok;
    repeat (len) @(posedge clk);
    #1 rst_b = 1'h1;
  endtask
  task automatic next_cs();
    for (int k = 0; k < 4 * DIV; k++) begin
      @(negedge clk);
      if (cs === 1'h1) break;
    end
  endtask
  task automatic pulses_until(input logic want, output int cnt);
    cnt = 0;
    for (int k = 0; k < 4000 && sw_on !== want; k++) begin
      @(negedge clk);
      if (cs === 1'h1) cnt++;
    end
  endtask
  task automatic wait_lvl(input ocsc_ilim_t want);
    for (int k = 0; k < 12 && lvl !== want; k++) next_cs();
  endtask
  task automatic t_heavy();
    pulses_until(1'h1, n);
    next_cs();
    repeat (2) @(negedge clk);
    check("gate on", gate, 1'h1);
    check("level", lvl, OCSC_ILIM_FULL);
    repeat (6) @(negedge clk);
    check("gate ilim off", gate, 1'h0);
    @(posedge clk) #1 ilim_dly = 8'hff;
    next_cs();
    repeat (8) @(negedge clk);
    check("gate window open", gate, 1'h1);
    repeat (6) @(negedge clk);
    check("gate window end", gate, 1'h0);
    ilim_dly = 8'h03;
    next_cs();
    @(posedge clk) #1 mode = 2'h2;
    // Enable is low inside the chip here while the current pulse still runs
    repeat (5) @(negedge clk);
    check("gate kept", gate, 1'h1);
    next_cs();
    repeat (2) @(negedge clk);
    check("gate skipped", gate, 1'h0);
    next_cs();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cs !== 1'h1 && n < 4 * DIV);
    check("osc period", n, DIV);
    $display("heavy and skip done");
  endtask
  task automatic t_levels();
    wait_lvl(OCSC_ILIM_MED);
    check("level med", lvl, OCSC_ILIM_MED);
    wait_lvl(OCSC_ILIM_LOW);
    check("level low", lvl, OCSC_ILIM_LOW);
    @(posedge clk) #1 mode = 2'h1;
    next_cs();
    next_cs();
    repeat (2) @(negedge clk);
    check("gate at low", gate, 1'h1);
    check("level still low", lvl, OCSC_ILIM_LOW);
    wait_lvl(OCSC_ILIM_FULL);
    check("level full", lvl, OCSC_ILIM_FULL);
    $display("levels done");
  endtask
  task automatic t_autorestart();
    do_reset(1'h0, 1'h0, 2);
    pulses_until(1'h1, n);
    pulses_until(1'h0, n);
    check("trip count", 32'(n >= NOFB - 1 && n <= NOFB + 2), 1);
    pulses_until(1'h1, n);
    check("first off", 32'(n >= ARF - 1 && n <= ARF + 2), 1);
    pulses_until(1'h0, n);
    pulses_until(1'h1, n);
    check("later off", 32'(n >= ARO - 1 && n <= ARO + 2), 1);
    $display("auto restart done");
  endtask
  task automatic t_line();
    do_reset(1'h1, 1'h0, 2);
    repeat (10 * DIV) @(negedge clk);
    check("held off", sw_on, 1'h0);
    check("no gate", gate, 1'h0);
    @(posedge clk) #1 line_sense_ok = 1'h1;
    pulses_until(1'h1, n);
    check("line up", sw_on, 1'h1);
    mode = 2'h0;
    repeat (30) next_cs();
    check("regulating", sw_on, 1'h1);
    mode = 2'h1;
    pulses_until(1'h0, n);
    repeat (3) @(negedge clk);
    check("latched", latched, 1'h1);
    repeat (70) next_cs();
    check("still latched", latched, 1'h1);
    @(posedge clk) #1 line_sense_ok = 1'h0;
    repeat (6) @(negedge clk);
    check("latch cleared", latched, 1'h0);
    check("no restart", sw_on, 1'h0);
    @(posedge clk) #1 line_sense_ok = 1'h1;
    pulses_until(1'h1, n);
    check("resumed", sw_on, 1'h1);
    mode = 2'h0;
    repeat (4) next_cs();
    @(posedge clk) #1 line_sense_ok = 1'h0;
    mode = 2'h1;
    pulses_until(1'h0, n);
    check("brownout count", 32'(n >= NOFB - 1 && n <= NOFB + 2), 1);
    repeat (3) @(negedge clk);
    check("no latch", latched, 1'h0);
    repeat (30) next_cs();
    check("stays off", sw_on, 1'h0);
    check("gate off", gate, 1'h0);
    $display("line sense done");
  endtask
  initial begin
    mode = 2'h1;
    ilim_dly = 8'h03;
    do_reset(1'h0, 1'h0, 10);
    t_heavy();
    t_levels();
    t_autorestart();
    t_line();
    complete_run();
  end
endmodule
`default_nettype wire
